// ### src/tsq_pkg.sv
// package: trace word layout, qualifier register map and shared types
`default_nettype none
package tsq_pkg;
  // ==========================================
  // trace word field positions
  localparam int TSQ_ADDR_LSB = 0;
  localparam int TSQ_ADDR_W = 24;
  localparam int TSQ_STAT_LSB = 24;
  localparam int TSQ_STAT_W = 8;
  localparam int TSQ_DMA_BIT = 30;
  localparam int TSQ_DATA_LSB = 32;
  localparam int TSQ_DATA_W = 16;
  localparam int TSQ_EDMA_BIT = 48;
  localparam int TSQ_BUS_CLEAR_REQUEST_BIT = 49;
  localparam int TSQ_CS_LSB = 50;
  localparam int TSQ_BUS_ERROR_LINE_BIT = 54;
  localparam int TSQ_ROM_BIT = 55;
  localparam int TSQ_GRD_BIT = 56;
  localparam int TSQ_PORT_LSB = 57;
  localparam int TSQ_IPL_LSB = 61;
  localparam int TSQ_BASE_CH = 48;
  localparam int TSQ_FULL_CH = 64;

  // ==========================================
  // register map: word offsets of the qualifier pattern, trace word and status registers
  localparam logic [3:0] TSQ_OFS_TRG_VAL_LO = 4'h0;
  localparam logic [3:0] TSQ_OFS_TRG_VAL_HI = 4'h1;
  localparam logic [3:0] TSQ_OFS_TRG_CARE_LO = 4'h2;
  localparam logic [3:0] TSQ_OFS_TRG_CARE_HI = 4'h3;
  localparam logic [3:0] TSQ_OFS_STO_VAL_LO = 4'h4;
  localparam logic [3:0] TSQ_OFS_STO_VAL_HI = 4'h5;
  localparam logic [3:0] TSQ_OFS_STO_CARE_LO = 4'h6;
  localparam logic [3:0] TSQ_OFS_STO_CARE_HI = 4'h7;
  localparam logic [3:0] TSQ_OFS_PRE_VAL_LO = 4'h8;
  localparam logic [3:0] TSQ_OFS_PRE_VAL_HI = 4'h9;
  localparam logic [3:0] TSQ_OFS_PRE_CARE_LO = 4'hA;
  localparam logic [3:0] TSQ_OFS_PRE_CARE_HI = 4'hB;
  localparam logic [3:0] TSQ_OFS_WORD_LO = 4'hC;
  localparam logic [3:0] TSQ_OFS_WORD_HI = 4'hD;
  localparam logic [3:0] TSQ_OFS_STATUS = 4'hE;
  localparam logic [31:0] TSQ_RST_VAL = 32'h0000_0000;
  localparam logic [31:0] TSQ_RST_CARE = 32'h0000_0000;

  // ==========================================
  // monitored processor bus cycle
  typedef struct packed {
    logic [2:0] interrupt_priority_lines;
    logic [3:0] upper_port_pins;
    logic guarded_n;
    logic rom_write_n;
    logic bus_error_line;
    logic [3:0] chip_select_lines;
    logic bus_clear_request;
    logic dma_internal;
    logic [15:0] data_lines;
    logic [7:0] status_lines;
    logic [23:0] address_lines;
  } tsq_bus_t;

  // one qualifier: value plus care mask (care 0 = don't care)
  typedef struct packed {
    logic [63:0] value;
    logic [63:0] care;
  } tsq_qual_t;

  // match results
  typedef struct packed {
    logic trigger;
    logic store;
    logic prestore;
  } tsq_hit_t;
endpackage : tsq_pkg
`default_nettype wire

// ### src/tsq_match.sv
// module: compares one trace word against one value and care pattern
`default_nettype none
module tsq_match
  import tsq_pkg::*;
#(
  parameter int CHANNELS = 64
) (
  input wire logic [63:0] word,
  input wire tsq_qual_t qual,
  output logic hit
);
  // ==========================================
  // channel gating
  // channels 48 to 63 are compared only when CHANNELS is 64 or more
  wire [63:0] chan_mask = (CHANNELS >= TSQ_FULL_CH) ? 64'hFFFF_FFFF_FFFF_FFFF
                                                    : 64'h0000_FFFF_FFFF_FFFF;
  // a cleared care bit excludes that bit from the compare
  wire [63:0] eff_care = qual.care & chan_mask;
  wire [63:0] diff = (word ^ qual.value) & eff_care;
  // every cared-for field must match in the same captured cycle
  assign hit = ~|diff;
endmodule : tsq_match
`default_nettype wire

// ### src/tsq_qualifier.sv
// module: trace word packer and trigger/store/prestore qualifier with register port
// ==========================================
`default_nettype none
module tsq_qualifier
  import tsq_pkg::*;
#(
  parameter int CHANNELS = 64
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cycle_valid,
  input wire tsq_bus_t bus_in,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [63:0] trace_word,
  output logic trace_valid,
  output tsq_hit_t hits
);
  // ==========================================
  // trace word packing
  logic [63:0] word_d;
  always_comb begin
    word_d = 64'h0000_0000_0000_0000;
    word_d[TSQ_ADDR_LSB +: TSQ_ADDR_W] = bus_in.address_lines;
    // status pins pass as-is, so the active-low dma flag lands on bit 30
    word_d[TSQ_STAT_LSB +: TSQ_STAT_W] = bus_in.status_lines;
    word_d[TSQ_DATA_LSB +: TSQ_DATA_W] = bus_in.data_lines;
    // upper channels only exist on the wide analyzer
    if (CHANNELS >= TSQ_FULL_CH) begin
      word_d[TSQ_EDMA_BIT] = bus_in.dma_internal;
      word_d[TSQ_BUS_CLEAR_REQUEST_BIT] = bus_in.bus_clear_request;
      word_d[TSQ_CS_LSB +: 4] = bus_in.chip_select_lines;
      word_d[TSQ_BUS_ERROR_LINE_BIT] = bus_in.bus_error_line;
      word_d[TSQ_ROM_BIT] = bus_in.rom_write_n;
      word_d[TSQ_GRD_BIT] = bus_in.guarded_n;
      word_d[TSQ_PORT_LSB +: 4] = bus_in.upper_port_pins;
      word_d[TSQ_IPL_LSB +: 3] = bus_in.interrupt_priority_lines;
    end
  end

  // ==========================================
  // qualifier pattern registers
  logic [31:0] regs_q [0:11];
  logic [31:0] regs_d [0:11];
  tsq_qual_t trg_qual, sto_qual, pre_qual;
  assign trg_qual = '{value: {regs_q[1], regs_q[0]}, care: {regs_q[3], regs_q[2]}};
  assign sto_qual = '{value: {regs_q[5], regs_q[4]}, care: {regs_q[7], regs_q[6]}};
  assign pre_qual = '{value: {regs_q[9], regs_q[8]}, care: {regs_q[11], regs_q[10]}};

  // writes to offsets beyond the pattern bank are ignored
  wire wr_hit = reg_wr && (reg_addr <= TSQ_OFS_PRE_CARE_HI);
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (wr_hit) begin
      regs_d[reg_addr] = reg_wdata;
    end
  end

  // reset clears every care mask, so all qualifiers start as match-any
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 12; i++) begin
        regs_q[i] <= i[1] ? TSQ_RST_CARE : TSQ_RST_VAL;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 12; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ==========================================
  // three comparators, one per qualifier
  logic trg_hit, sto_hit, pre_hit;
  tsq_match #(.CHANNELS(CHANNELS)) u_trg (.word(word_d), .qual(trg_qual), .hit(trg_hit));
  tsq_match #(.CHANNELS(CHANNELS)) u_sto (.word(word_d), .qual(sto_qual), .hit(sto_hit));
  tsq_match #(.CHANNELS(CHANNELS)) u_pre (.word(word_d), .qual(pre_qual), .hit(pre_hit));

  // ==========================================
  // registered outputs: word and hits describe the same bus cycle
  tsq_hit_t hits_d;
  assign hits_d = '{trigger: cycle_valid & trg_hit,
                    store: cycle_valid & sto_hit,
                    prestore: cycle_valid & pre_hit};
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trace_word <= 64'h0000_0000_0000_0000;
      trace_valid <= 1'b0;
      hits <= '0;
    end else if (clk_en) begin
      trace_valid <= cycle_valid;
      hits <= hits_d;
      if (cycle_valid) begin
        trace_word <= word_d;
      end
    end
  end

  // ==========================================
  // read mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr <= TSQ_OFS_PRE_CARE_HI) begin
      rd_mux = regs_q[reg_addr];
    end else if (reg_addr == TSQ_OFS_WORD_LO) begin
      rd_mux = trace_word[31:0];
    end else if (reg_addr == TSQ_OFS_WORD_HI) begin
      rd_mux = trace_word[63:32];
    end else if (reg_addr == TSQ_OFS_STATUS) begin
      rd_mux = {28'h000_0000, trace_valid, hits};
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================
  // checks
  sequence cyc_s;
    clk_en && cycle_valid;
  endsequence
  // extended channels exist only on the wide analyzer
  localparam bit WIDE = CHANNELS >= TSQ_FULL_CH;
  sequence wide_cyc_s;
    clk_en && cycle_valid && WIDE;
  endsequence
  addr_field_a: assert property (@(posedge clock) disable iff (!rst_n)
    cyc_s |=> trace_word[23:0] == $past(bus_in.address_lines))
    else $error("address field wrong");
  data_field_a: assert property (@(posedge clock) disable iff (!rst_n)
    cyc_s |=> trace_word[47:32] == $past(bus_in.data_lines))
    else $error("data field wrong");
  status_field_a: assert property (@(posedge clock) disable iff (!rst_n)
    cyc_s |=> trace_word[31:24] == $past(bus_in.status_lines))
    else $error("status field wrong");
  dma_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    cyc_s |=> trace_word[30] == $past(bus_in.status_lines[6]))
    else $error("dma status bit wrong");
  edma_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[TSQ_EDMA_BIT] == $past(bus_in.dma_internal))
    else $error("dma source bit wrong");
  extra_fields_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[63:49] == $past({bus_in.interrupt_priority_lines,
      bus_in.upper_port_pins, bus_in.guarded_n, bus_in.rom_write_n, bus_in.bus_error_line,
      bus_in.chip_select_lines, bus_in.bus_clear_request}))
    else $error("extended fields wrong");
  narrow_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cycle_valid && !WIDE |=> trace_word[63:48] == 16'h0000)
    else $error("upper channels present on narrow analyzer");
  no_care_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cycle_valid && sto_qual.care == 64'h0 && !wr_hit |=> hits.store)
    else $error("empty care mask did not match");
  trig_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en |=> hits.trigger == $past(cycle_valid && ((word_d ^ trg_qual.value)
      & trg_qual.care & ((CHANNELS >= 64) ? ~64'h0 : 64'h0000_FFFF_FFFF_FFFF)) == 64'h0))
    else $error("trigger match wrong");

  // ==========================================
  // match checks for the other two qualifiers
  // mask of the channels this build captures; shared by the store and prestore match checks
  function automatic logic [63:0] chan_mask_f();
    chan_mask_f = 64'h0000_FFFF_FFFF_FFFF;
    if (CHANNELS >= TSQ_FULL_CH) begin
      chan_mask_f = 64'hFFFF_FFFF_FFFF_FFFF;
    end
  endfunction

  // store hit follows its own pattern, not the trigger's
  store_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en |=> hits.store == $past(cycle_valid && ((word_d ^ sto_qual.value)
      & sto_qual.care & chan_mask_f()) == 64'h0))
    else $error("store match wrong");

  // prestore hit follows its own pattern
  pre_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en |=> hits.prestore == $past(cycle_valid && ((word_d ^ pre_qual.value)
      & pre_qual.care & chan_mask_f()) == 64'h0))
    else $error("prestore match wrong");

  // an all don't-care trigger matches every captured cycle
  trg_empty_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cycle_valid && trg_qual.care == 64'h0 && !wr_hit |=> hits.trigger)
    else $error("empty trigger mask did not match");

  // an all don't-care prestore matches every captured cycle
  pre_empty_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && cycle_valid && pre_qual.care == 64'h0 && !wr_hit |=> hits.prestore)
    else $error("empty prestore mask did not match");

  // a hit without a captured cycle would point at a stale word
  hit_valid_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|hits) |-> trace_valid)
    else $error("hit without valid cycle");

  // ==========================================
  // extended channel checks, one per field
  // the combined check above cannot tell which field moved; these can
  bus_clear_request_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[TSQ_BUS_CLEAR_REQUEST_BIT] == $past(bus_in.bus_clear_request))
    else $error("bus clear bit wrong");

  // bus error stays active low in the word
  bus_error_line_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[TSQ_BUS_ERROR_LINE_BIT] == $past(bus_in.bus_error_line))
    else $error("bus error bit wrong");

  // write-to-rom flag stays active low in the word
  rom_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[TSQ_ROM_BIT] == $past(bus_in.rom_write_n))
    else $error("rom write bit wrong");

  // guarded access flag stays active low in the word
  grd_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[TSQ_GRD_BIT] == $past(bus_in.guarded_n))
    else $error("guarded bit wrong");

  // chip selects keep their order
  cs_field_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[53:50] == $past(bus_in.chip_select_lines))
    else $error("chip select field wrong");

  // interrupt priority keeps its order
  ipl_field_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[63:61] == $past(bus_in.interrupt_priority_lines))
    else $error("interrupt priority field wrong");

  // port pins keep their order
  port_field_a: assert property (@(posedge clock) disable iff (!rst_n)
    wide_cyc_s |=> trace_word[60:57] == $past(bus_in.upper_port_pins))
    else $error("port pin field wrong");

  // ==========================================
  // capture timing checks
  // trace_valid is a one-cycle copy of the capture strobe
  valid_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en |=> trace_valid == $past(cycle_valid))
    else $error("trace valid not aligned");

  // the word of the last cycle stays readable between cycles
  word_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !cycle_valid |=> $stable(trace_word))
    else $error("trace word moved without a cycle");

  // a low enable freezes every output
  freeze_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(trace_word) && $stable(trace_valid) && $stable(hits)
      && $stable(reg_rdata))
    else $error("outputs moved while frozen");

  // a low enable also freezes the pattern bank
  freeze_regs_a: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(trg_qual) && $stable(sto_qual) && $stable(pre_qual))
    else $error("patterns moved while frozen");

  // ==========================================
  // register port checks
  // read data stand only in the cycle after the strobe
  rd_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data without a read");

  // unmapped offsets read zero
  rd_unmapped_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == 4'hF |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped offset not zero");

  // low half of the last word
  rd_word_lo_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == TSQ_OFS_WORD_LO |=> reg_rdata == $past(trace_word[31:0]))
    else $error("word low read wrong");

  // high half of the last word
  rd_word_hi_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == TSQ_OFS_WORD_HI |=> reg_rdata == $past(trace_word[63:32]))
    else $error("word high read wrong");

  // status word shows valid and the three hits
  rd_status_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == TSQ_OFS_STATUS
      |=> reg_rdata == {28'h000_0000, $past(trace_valid), $past(hits)})
    else $error("status read wrong");

  // a pattern written and read back two cycles later returns the written word
  sequence wr_rd_s;
    (clk_en && wr_hit) ##1 (clk_en && !reg_wr) ##1
      (clk_en && reg_rd && reg_addr == $past(reg_addr, 2));
  endsequence
  wr_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_rd_s |=> reg_rdata == $past(reg_wdata, 3))
    else $error("pattern readback wrong");

  // ==========================================
  // reset checks
  // reset works even with the enable low, so no disable here
  reset_out_a: assert property (@(posedge clock)
    !rst_n |=> trace_valid == 1'b0 && hits == '0 && reg_rdata == 32'h0000_0000
      && trace_word == 64'h0000_0000_0000_0000)
    else $error("outputs not cleared by reset");

  // after reset every qualifier is match-any
  reset_care_a: assert property (@(posedge clock)
    !rst_n |=> trg_qual.care == 64'h0 && sto_qual.care == 64'h0
      && pre_qual.care == 64'h0)
    else $error("care masks not cleared by reset");
endmodule : tsq_qualifier
`default_nettype wire

// ### tb/tsq_bus_model.sv
// partner model: processor bus presenting one captured cycle at a time
`default_nettype none
module tsq_bus_model
  import tsq_pkg::*;
(
  input wire logic clock,
  output var logic cycle_valid,
  output var tsq_bus_t bus_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // idle lines show the inverse of the last cycle so stale levels never match
  initial begin
    cycle_valid = 1'b0;
    bus_in = '1;
  end
  task automatic send(input tsq_bus_t b);
    @(posedge clock);
    cycle_valid <= 1'b1;
    bus_in <= b;
    @(posedge clock);
    cycle_valid <= 1'b0;
    bus_in <= ~b;
  endtask
endmodule // tsq_bus_model
`default_nettype wire

// ### tb/trace_state_qualifier_tb.sv
// testbench: trace word packing and qualifier matching
`default_nettype none
module trace_state_qualifier_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tsq_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [63:0] trace_word;
  logic trace_valid;
  logic cycle_valid;
  tsq_bus_t bus_in;
  tsq_hit_t hits;
  int n_mismatch = 0;
  int n_compared = 0;
  // ==========================================
  // clock, design and bus partner
  always #50 clock = ~clock;
  tsq_qualifier #(.CHANNELS(64)) dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .cycle_valid(cycle_valid), .bus_in(bus_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trace_word(trace_word), .trace_valid(trace_valid), .hits(hits));
  tsq_bus_model bm (.clock(clock), .cycle_valid(cycle_valid), .bus_in(bus_in));
  // narrow build on the same bus: upper channels must stay empty
  logic [63:0] trace_word_narrow;
  tsq_qualifier #(.CHANNELS(48)) dut_narrow (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .cycle_valid(cycle_valid), .bus_in(bus_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .trace_word(trace_word_narrow), .trace_valid(), .hits());
  // ==========================================
  // shared helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk({32'h0, reg_rdata}, {32'h0, e}, "read data");
  endtask
  task automatic setq(input logic [3:0] b, input logic [63:0] v, input logic [63:0] c);
    wr(b, v[31:0]);
    wr(b + 4'h1, v[63:32]);
    wr(b + 4'h2, c[31:0]);
    wr(b + 4'h3, c[63:32]);
  endtask
  task automatic cyc(input tsq_bus_t b, input logic [2:0] eh);
    bm.send(b);
    #1 chk({63'h0, trace_valid}, 64'h1, "trace valid");
    chk({61'h0, hits}, {61'h0, eh}, "hits");
  endtask
  // expected word built field by field at the documented bit positions
  function automatic logic [63:0] pack(tsq_bus_t b);
    pack = 64'h0;
    pack[23:0] = b.address_lines;
    pack[31:24] = b.status_lines;
    pack[47:32] = b.data_lines;
    pack[48] = b.dma_internal;
    pack[49] = b.bus_clear_request;
    pack[53:50] = b.chip_select_lines;
    pack[54] = b.bus_error_line;
    pack[55] = b.rom_write_n;
    pack[56] = b.guarded_n;
    pack[60:57] = b.upper_port_pins;
    pack[63:61] = b.interrupt_priority_lines;
  endfunction
  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 16; i++) rd(4'(i), 32'h0);
  endtask
  // zero care masks: every cycle matches; two opposite patterns move every field
  task automatic t_pack();
    tsq_bus_t b;
    b = tsq_bus_t'(64'hA5C3_1E69_5AF0_3C96);
    for (int k = 0; k < 2; k++) begin
      cyc(b, 3'b111);
      chk(trace_word, pack(b), "trace word");
      chk(trace_word_narrow, pack(b) & 64'h0000_FFFF_FFFF_FFFF, "narrow word");
      rd(TSQ_OFS_WORD_LO, 32'(pack(b)));
      rd(TSQ_OFS_WORD_HI, 32'(pack(b) >> 32));
      b = ~b;
    end
  endtask
  // low clock enable freezes capture
  task automatic t_freeze();
    clk_en <= 1'b0;
    bm.send(tsq_bus_t'(64'h1));
    #1 chk({63'h0, trace_valid}, 64'h0, "frozen valid");
    chk(trace_word, 64'h5A3C_E196_A50F_C369, "frozen word");
    clk_en <= 1'b1;
  endtask
  // trigger: address, dma status; store: data; prestore: dma source, bus clear, chip selects; break each but chip selects alone
  task automatic t_match();
    tsq_bus_t b;
    setq(TSQ_OFS_TRG_VAL_LO, 64'h0000_0000_0012_3456, 64'h0000_0000_40FF_FFFF);
    setq(TSQ_OFS_STO_VAL_LO, 64'h0000_BEEF_0000_0000, 64'h0000_FF0F_0000_0000);
    setq(TSQ_OFS_PRE_VAL_LO, 64'h0029_0000_0000_0000, 64'h003F_0000_0000_0000);
    rd(TSQ_OFS_PRE_CARE_HI, 32'h003F_0000);
    b = '0;
    b.address_lines = 24'h123456;
    b.data_lines = 16'hBEEF;
    b.dma_internal = 1'b1;
    b.chip_select_lines = 4'hA;
    cyc(b, 3'b111);
    b.data_lines = 16'hBE0F;
    cyc(b, 3'b111);
    b.data_lines = 16'hBEEE;
    cyc(b, 3'b101);
    b.data_lines = 16'hBEEF;
    b.address_lines = 24'h123457;
    cyc(b, 3'b011);
    b.address_lines = 24'h123456;
    b.status_lines[6] = 1'b1;
    cyc(b, 3'b011);
    b.status_lines[6] = 1'b0;
    b.dma_internal = 1'b0;
    cyc(b, 3'b110);
    b.dma_internal = 1'b1;
    b.bus_clear_request = 1'b1;
    cyc(b, 3'b110);
  endtask
  // ==========================================
  // verdict, watchdog and main sequence
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_pack();
    t_freeze();
    t_match();
    give_verdict();
  end
endmodule // trace_state_qualifier_tb
`default_nettype wire
